//--- rtl/sftl_top.sv
// supply fault threshold logic top with apb register file
`timescale 1ns/10ps
`include "sftl_regs.svh"

// What this block does
// - ten supervised inputs, five dedicated detectors and five dual-function inputs.
// - each dual-function input is either an analog detector or a logic input, never both.
// - each detector does undervoltage, overvoltage or out-of-window detection.
// - thresholds are 8-bit codes scaled by span times code over 255 plus range bottom.
// - four ranges; high-voltage uses the upper two, positives the lower three, duals the lowest.
// - comparisons run continuously, not on request.
// - an undervoltage fault clears only above threshold plus hysteresis.
// - an overvoltage fault clears only below threshold minus hysteresis.
// - hysteresis is a 5-bit code scaled by span times code over 255.
// - the hysteresis code is at most 31.
// - sequencing waits until interchip bus synchronisation is complete.
// - each detector output is glitch filtered by the programmed timeout.
module sftl_top
    import sftl_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // digitised rail samples in millivolts
    input wire sftl_samples_t sample_mv,
    // dual-function pins used as logic
    input wire logic [4:0] dual_function_inputs,
    // interchip bus synchronisation
    input wire logic interchip_bus_sync_done,
    // results
    output logic [9:0] supply_fault_detector,
    output logic [4:0] logic_level,
    output logic seq_enable
);

    ////////////////////////////////////////////////////////////////////////////
    // storage and decoded configuration

    logic [31:0] cfg0_word [`SFTL_NUM_CH];
    logic [31:0] cfg1_word [`SFTL_NUM_CH];
    sftl_chan_cfg_t chan_cfg [`SFTL_NUM_CH];
    sftl_limits_t lim [`SFTL_NUM_CH];
    logic [9:0] uv_flag;
    logic [9:0] ov_flag;
    logic [9:0] raw_fault;
    logic [9:0] filt_fault;
    logic ctrl_seq_req;
    logic [4:0] dual_meta;
    logic [4:0] dual_sync;
    logic sync_meta;
    logic sync_done;
    logic [31:0] byte_mask;
    logic [3:0] ch_idx;
    logic ch_hit;
    logic ch_cfg1;
    logic wr_en;
    logic setup_rd;
    logic [31:0] next_prdata;
    logic next_slverr;

    ////////////////////////////////////////////////////////////////////////////
    // helper functions

    function automatic logic [1:0] legal_range(input int ch, input logic [1:0] req);
        logic [1:0] r;
        r = req;
        if (ch == 0) begin
            if (r < 2'h2) begin
                r = 2'h2;
            end
        end else if (ch < `SFTL_FIRST_DUAL) begin
            if (r == 2'h3) begin
                r = 2'h2;
            end
        end else begin
            r = 2'h0;
        end
        return r;
    endfunction

    function automatic logic [15:0] range_bot(input logic [1:0] r);
        logic [15:0] v;
        v = `SFTL_R0_BOT;
        case (r)
            2'h1: v = `SFTL_R1_BOT;
            2'h2: v = `SFTL_R2_BOT;
            2'h3: v = `SFTL_R3_BOT;
            default: v = `SFTL_R0_BOT;
        endcase
        return v;
    endfunction

    function automatic logic [15:0] range_span(input logic [1:0] r);
        logic [15:0] v;
        v = `SFTL_R0_SPAN;
        case (r)
            2'h1: v = `SFTL_R1_SPAN;
            2'h2: v = `SFTL_R2_SPAN;
            2'h3: v = `SFTL_R3_SPAN;
            default: v = `SFTL_R0_SPAN;
        endcase
        return v;
    endfunction

    // span times code over full scale
    function automatic logic [15:0] scale_code(input logic [15:0] span, input logic [7:0] code);
        logic [21:0] prod;
        prod = 22'(span) * 22'(code);
        return 16'(prod / `SFTL_CODE_FULL);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    assign ch_idx = paddr[6:3];
    assign ch_cfg1 = paddr[2];
    assign ch_hit = ({24'h000000, paddr} < `SFTL_CH_SPACE_END) && (paddr[1:0] == 2'h0);
    assign wr_en = psel && penable && pwrite;
    assign setup_rd = psel && !penable;
    assign pready = psel && penable;

    generate
        for (genvar b = 0; b < 4; b++) begin : g_mask
            assign byte_mask[8*b+7:8*b] = {8{pstrb[b]}};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // apb read mux

    always_comb begin
        next_prdata = 32'h0000_0000;
        next_slverr = 1'b0;
        if (ch_hit) begin
            if (ch_cfg1) begin
                next_prdata = cfg1_word[ch_idx];
            end else begin
                next_prdata = cfg0_word[ch_idx];
            end
        end else if ({24'h000000, paddr} == `SFTL_OFF_STATUS) begin
            next_prdata = {14'h0000, seq_enable, sync_done, 6'h00, supply_fault_detector};
        end else if ({24'h000000, paddr} == `SFTL_OFF_CTRL) begin
            next_prdata = {31'h0000_0000, ctrl_seq_req};
        end else if ({24'h000000, paddr} == `SFTL_OFF_LOGIC) begin
            next_prdata = {27'h000_0000, logic_level};
        end else if ({24'h000000, paddr} == `SFTL_OFF_FLAGS) begin
            next_prdata = {6'h00, ov_flag, 6'h00, uv_flag};
        end else begin
            next_slverr = 1'b1;
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_rd) begin
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= next_slverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control and sequencing

    // control register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl_seq_req <= `SFTL_CTRL_RST;
        end else if (wr_en && pstrb[0] && {24'h000000, paddr} == `SFTL_OFF_CTRL) begin
            ctrl_seq_req <= pwdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dual_meta <= 5'h00;
            dual_sync <= 5'h00;
            sync_meta <= 1'b0;
            sync_done <= 1'b0;
        end else begin
            dual_meta <= dual_function_inputs;
            dual_sync <= dual_meta;
            sync_meta <= interchip_bus_sync_done;
            sync_done <= sync_meta;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            seq_enable <= 1'b0;
        end else begin
            seq_enable <= ctrl_seq_req && sync_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // dual-function logic levels

    // logic use only when not analog
    generate
        for (genvar d = 0; d < `SFTL_NUM_DUAL; d++) begin : g_lvl
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    logic_level[d] <= 1'b0;
                end else begin
                    logic_level[d] <= dual_sync[d]
                        && !chan_cfg[`SFTL_FIRST_DUAL + d].analog_sel;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // per channel detectors

    generate
        for (genvar i = 0; i < `SFTL_NUM_CH; i++) begin : g_ch
            logic [1:0] rng;
            logic [15:0] s;
            logic [16:0] uv_release;
            logic [16:0] ov_release;
            logic active;

            // configuration words
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    cfg0_word[i] <= `SFTL_CFG0_RST;
                    cfg1_word[i] <= `SFTL_CFG1_RST;
                end else if (wr_en && ch_hit && ch_idx == 4'(i)) begin
                    if (ch_cfg1) begin
                        cfg1_word[i] <= ((cfg1_word[i] & ~byte_mask) | (pwdata & byte_mask))
                            & `SFTL_CFG1_MASK;
                    end else begin
                        cfg0_word[i] <= ((cfg0_word[i] & ~byte_mask) | (pwdata & byte_mask))
                            & `SFTL_CFG0_MASK;
                    end
                end
            end

            // field decode
            always_comb begin
                chan_cfg[i].uv_code = cfg0_word[i][`SFTL_UV_LSB +: 8];
                chan_cfg[i].ov_code = cfg0_word[i][`SFTL_OV_LSB +: 8];
                // five bit code caps at 31
                chan_cfg[i].hyst_code = cfg0_word[i][`SFTL_HYST_LSB +: 5] & `SFTL_HYST_MAX;
                chan_cfg[i].mode = cfg1_word[i][`SFTL_MODE_LSB +: 2];
                chan_cfg[i].range_sel = cfg1_word[i][`SFTL_RANGE_LSB +: 2];
                chan_cfg[i].analog_sel = (i < `SFTL_FIRST_DUAL) ? 1'b1
                    : cfg1_word[i][`SFTL_ANALOG_LSB];
                chan_cfg[i].glitch_cyc = (cfg1_word[i][`SFTL_GLITCH_LSB +: 10]
                    > 10'(`SFTL_GLITCH_MAX_CYC)) ? 10'(`SFTL_GLITCH_MAX_CYC)
                    : cfg1_word[i][`SFTL_GLITCH_LSB +: 10];
            end

            assign rng = legal_range(i, chan_cfg[i].range_sel);
            assign lim[i].uv_mv = scale_code(range_span(rng), chan_cfg[i].uv_code) + range_bot(rng);
            assign lim[i].ov_mv = scale_code(range_span(rng), chan_cfg[i].ov_code) + range_bot(rng);
            assign lim[i].hyst_mv = scale_code(range_span(rng), {3'h0, chan_cfg[i].hyst_code});

            assign s = sample_mv[i];
            assign uv_release = {1'b0, lim[i].uv_mv} + {1'b0, lim[i].hyst_mv};
            assign ov_release = {1'b0, lim[i].ov_mv} - {1'b0, lim[i].hyst_mv};
            // dual input as detector only in analog use
            assign active = chan_cfg[i].analog_sel && (chan_cfg[i].mode != `SFTL_MODE_OFF);

            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    uv_flag[i] <= 1'b0;
                end else if (!active) begin
                    uv_flag[i] <= 1'b0;
                end else if (s < lim[i].uv_mv) begin
                    uv_flag[i] <= 1'b1;
                end else if ({1'b0, s} > uv_release) begin
                    uv_flag[i] <= 1'b0;
                end
            end

            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    ov_flag[i] <= 1'b0;
                end else if (!active) begin
                    ov_flag[i] <= 1'b0;
                end else if (s > lim[i].ov_mv) begin
                    ov_flag[i] <= 1'b1;
                end else if (lim[i].hyst_mv <= lim[i].ov_mv && {1'b0, s} < ov_release) begin
                    ov_flag[i] <= 1'b0;
                end else if (lim[i].hyst_mv > lim[i].ov_mv) begin
                    ov_flag[i] <= ov_flag[i];
                end
            end

            always_comb begin
                raw_fault[i] = 1'b0;
                case (chan_cfg[i].mode)
                    `SFTL_MODE_UV: raw_fault[i] = uv_flag[i];
                    `SFTL_MODE_OV: raw_fault[i] = ov_flag[i];
                    `SFTL_MODE_WIN: raw_fault[i] = uv_flag[i] | ov_flag[i];
                    default: raw_fault[i] = 1'b0;
                endcase
            end

            sftl_glitch u_glitch (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .raw_in(raw_fault[i]),
                .timeout_cyc(chan_cfg[i].glitch_cyc),
                .filt_out(filt_fault[i])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // fault outputs

    assign supply_fault_detector = filt_fault;

endmodule

//--- rtl/sftl_regs.svh
// register map, field positions, reset values and timing counts
`ifndef SFTL_REGS_SVH
`define SFTL_REGS_SVH

// channel counts
`define SFTL_NUM_CH 10
`define SFTL_NUM_DUAL 5
`define SFTL_FIRST_DUAL 5

// register byte offsets
`define SFTL_CH_STRIDE 8
`define SFTL_OFF_CFG0 32'h0000_0000
`define SFTL_OFF_CFG1 32'h0000_0004
`define SFTL_OFF_STATUS 32'h0000_0080
`define SFTL_OFF_CTRL 32'h0000_0084
`define SFTL_OFF_LOGIC 32'h0000_0088
`define SFTL_OFF_FLAGS 32'h0000_008c
`define SFTL_CH_SPACE_END 32'h0000_0050

// cfg0 fields
`define SFTL_UV_LSB 0
`define SFTL_OV_LSB 8
`define SFTL_HYST_LSB 16
`define SFTL_CFG0_MASK 32'h001f_ffff
// cfg1 fields
`define SFTL_MODE_LSB 0
`define SFTL_RANGE_LSB 8
`define SFTL_ANALOG_LSB 12
`define SFTL_GLITCH_LSB 16
`define SFTL_CFG1_MASK 32'h03ff_1303
// status and flags fields
`define SFTL_SYNC_BIT 16
`define SFTL_SEQ_BIT 17
`define SFTL_OV_FLAG_LSB 16

// reset values
`define SFTL_CFG0_RST 32'h0000_0000
`define SFTL_CFG1_RST 32'h0000_0000
`define SFTL_CTRL_RST 1'b0

// detection mode codes
`define SFTL_MODE_OFF 2'h0
`define SFTL_MODE_UV 2'h1
`define SFTL_MODE_OV 2'h2
`define SFTL_MODE_WIN 2'h3

// range bottoms and spans in millivolts
`define SFTL_R0_BOT 16'h023d
`define SFTL_R0_SPAN 16'h0322
`define SFTL_R1_BOT 16'h04e2
`define SFTL_R1_SPAN 16'h06d6
`define SFTL_R2_BOT 16'h09c4
`define SFTL_R2_SPAN 16'h0dac
`define SFTL_R3_BOT 16'h1770
`define SFTL_R3_SPAN 16'h20d0
`define SFTL_CODE_FULL 22'h0000ff
`define SFTL_HYST_MAX 5'h1f

// glitch filter timing
`define SFTL_CLK_HZ 10000000
`define SFTL_GLITCH_MAX_US 100
`define SFTL_GLITCH_MAX_CYC (`SFTL_GLITCH_MAX_US * (`SFTL_CLK_HZ / 1000000))

`endif

//--- rtl/sftl_pkg.sv
// types shared by the supply fault threshold logic
package sftl_pkg;

    typedef struct packed {
        logic [7:0] uv_code;
        logic [7:0] ov_code;
        logic [4:0] hyst_code;
        logic [1:0] mode;
        logic [1:0] range_sel;
        logic analog_sel;
        logic [9:0] glitch_cyc;
    } sftl_chan_cfg_t;

    typedef struct packed {
        logic [15:0] uv_mv;
        logic [15:0] ov_mv;
        logic [15:0] hyst_mv;
    } sftl_limits_t;

    typedef logic [9:0][15:0] sftl_samples_t;

endpackage

//--- rtl/sftl_glitch.sv
// glitch filter for one detector output
`timescale 1ns/10ps
module sftl_glitch
    import sftl_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // filter
    input wire logic raw_in,
    input wire logic [9:0] timeout_cyc,
    output logic filt_out
);

    logic [9:0] run_cnt;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            run_cnt <= 10'h000;
        end else if (raw_in == filt_out) begin
            run_cnt <= 10'h000;
        end else if (run_cnt < timeout_cyc) begin
            run_cnt <= run_cnt + 10'h001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            filt_out <= 1'b0;
        end else if (raw_in != filt_out && run_cnt >= timeout_cyc) begin
            filt_out <= raw_in;
        end
    end

endmodule

//--- verif/sftl_rails.sv
// model of the monitored supply rails
`timescale 1ns/10ps
module sftl_rails
    import sftl_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // rail update
    input wire logic load,
    input wire logic [3:0] ch,
    input wire logic [15:0] mv,
    // rail voltages
    output sftl_samples_t sample_mv
);
    initial begin
        sample_mv = {10{16'h07d0}};
        forever begin
            @(posedge sys_clk);
            if (load) begin
                sample_mv[ch] <= mv;
            end
        end
    end
endmodule

//--- verif/sftl_top_asserts.sv
// port checker for the supply fault logic
`timescale 1ns/10ps
module sftl_top_asserts
    import sftl_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // sync and results
    input wire logic interchip_bus_sync_done,
    input wire logic [9:0] supply_fault_detector,
    input wire logic seq_enable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic ctrl_copy;
    logic setup;
    logic bad;
    assign setup = psel && !penable;
    assign bad = paddr[1:0] != 2'h0 || paddr >= 8'h90 || (paddr >= 8'h50 && paddr < 8'h80);
    ////////////////////////////////////////////////////////////////
    // shadow of the sequencing request
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl_copy <= 1'b0;
        end else if (psel && penable && pwrite && paddr == 8'h84 && pstrb[0]) begin
            ctrl_copy <= pwdata[0];
        end
    end
    ////////////////////////////////////////////////////////////////
    a_ready_zero_wait: assert property (pready == (psel && penable))
        else $error("pready not psel and penable");
    a_reset_clears: assert property (disable iff (1'b0)
        sys_rst |=> supply_fault_detector == 10'h0 && !seq_enable) else $error("reset not clear");
    a_err_bad_addr: assert property (setup && bad |=> pslverr)
        else $error("no error on unmapped");
    a_err_good_addr: assert property (setup && !bad |=> !pslverr)
        else $error("error on mapped");
    a_read_zero: assert property (setup && !pwrite && bad |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_fault_delay: assert property ((supply_fault_detector & ~$past(supply_fault_detector))
        != 10'h0 |-> !$past(sys_rst) && !$past(sys_rst, 2)) else $error("fault too early");
    a_seq_sync: assert property (seq_enable |-> $past(interchip_bus_sync_done, 3))
        else $error("sequencing before sync");
    a_seq_ctrl: assert property (seq_enable |-> $past(ctrl_copy))
        else $error("sequencing without request");
    c_err: cover property (setup && bad);
    c_seq: cover property ($rose(seq_enable));
    c_fault: cover property ($rose(supply_fault_detector[2]));
endmodule
bind sftl_top sftl_top_asserts u_chk (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .interchip_bus_sync_done,
    .supply_fault_detector, .seq_enable);

//--- verif/supply_fault_threshold_logic_tb.sv
// bench for the supply fault threshold logic
`timescale 1ns/10ps
`include "sftl_regs.svh"
module supply_fault_threshold_logic_tb
    import sftl_pkg::*;
;
    logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err, sync_in, seq_en, ld;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, rch;
    logic [4:0] dual_in, lvl;
    logic [9:0] fault;
    logic [15:0] rmv;
    sftl_samples_t sample_mv;
    int miscompares, checks, uv, hy, ov, oh;
    sftl_top dut (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .sample_mv, .dual_function_inputs(dual_in),
        .interchip_bus_sync_done(sync_in), .supply_fault_detector(fault),
        .logic_level(lvl), .seq_enable(seq_en));
    sftl_rails rails (.sys_clk, .load(ld), .ch(rch), .mv(rmv), .sample_mv);
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    function automatic int lim(int b, int s, int c);
        return s * c / 255 + b;
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        chk(n, {31'h0000_0000, e}, {31'h0000_0000, g});
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rail(input logic [3:0] c, input int v, input int n);
        @(posedge sys_clk);
        ld <= 1'b1;
        rch <= c;
        rmv <= 16'(v);
        @(posedge sys_clk);
        ld <= 1'b0;
        repeat (n) @(posedge sys_clk);
    endtask
    task complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge sys_clk);
        miscompares++;
        complete_run();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, paddr, pwdata, ld, rch, rmv, sync_in} <= '0;
        pstrb <= 4'hf;
        dual_in <= 5'h1f;
        sys_rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        xfer(1'b0, 8'h04, 32'h0000_0000);
        chk("cfg1 reset", `SFTL_CFG1_RST, rd);
        xfer(1'b0, 8'h90, 32'h0000_0000);
        chk1("unmapped err", 1'b1, err);
        chk("unmapped data", 32'h0000_0000, rd);
        xfer(1'b1, 8'h48, 32'hffff_ffff);
        xfer(1'b0, 8'h48, 32'h0000_0000);
        chk("hyst width", `SFTL_CFG0_MASK, rd);
        uv = lim(`SFTL_R1_BOT, `SFTL_R1_SPAN, 100);
        hy = `SFTL_R1_SPAN * 10 / 255;
        xfer(1'b1, 8'h10, 32'h000a_0064);
        xfer(1'b1, 8'h14, 32'h0000_0101);
        rail(4'h2, uv - 1, 5);
        chk1("uv set", 1'b1, fault[2]);
        xfer(1'b0, 8'h8c, 32'h0000_0000);
        chk1("uv flag", 1'b1, rd[2]);
        rail(4'h2, uv + hy, 5);
        chk1("uv held", 1'b1, fault[2]);
        rail(4'h2, uv + hy + 1, 5);
        chk1("uv clear", 1'b0, fault[2]);
        xfer(1'b1, 8'h14, 32'h0014_0101);
        rail(4'h2, uv - 1, 10);
        rail(4'h2, uv + hy + 1, 30);
        chk1("short pulse", 1'b0, fault[2]);
        rail(4'h2, uv - 1, 15);
        chk1("long pending", 1'b0, fault[2]);
        repeat (15) @(posedge sys_clk);
        chk1("long pass", 1'b1, fault[2]);
        xfer(1'b1, 8'h14, 32'h0000_0000);
        repeat (30) @(posedge sys_clk);
        chk1("mode off", 1'b0, fault[2]);
        ov = lim(`SFTL_R3_BOT, `SFTL_R3_SPAN, 182);
        oh = `SFTL_R3_SPAN * 31 / 255;
        xfer(1'b1, 8'h00, 32'h001f_b600);
        xfer(1'b1, 8'h04, 32'h0000_0302);
        rail(4'h0, ov + 1, 5);
        chk1("ov set", 1'b1, fault[0]);
        rail(4'h0, ov - oh, 5);
        chk1("ov held", 1'b1, fault[0]);
        rail(4'h0, ov - oh - 1, 5);
        chk1("ov clear", 1'b0, fault[0]);
        xfer(1'b1, 8'h04, 32'h0000_0002);
        repeat (5) @(posedge sys_clk);
        chk1("hv range clamp", 1'b1, fault[0]);
        // below the clamped release level, above any lower range limit
        rail(4'h0, 3000, 5);
        chk1("hv range floor", 1'b0, fault[0]);
        // window on an analog dual input
        rail(4'h5, 1000, 0);
        xfer(1'b1, 8'h28, 32'h0000_ff00);
        xfer(1'b1, 8'h2c, 32'h0000_1303);
        repeat (5) @(posedge sys_clk);
        chk1("window inside", 1'b0, fault[5]);
        chk1("analog level", 1'b0, lvl[0]);
        chk1("logic level", 1'b1, lvl[1]);
        rail(4'h5, `SFTL_R0_BOT - 1, 5);
        chk1("window low", 1'b1, fault[5]);
        rail(4'h5, 1000, 5);
        chk1("window back", 1'b0, fault[5]);
        rail(4'h5, `SFTL_R0_BOT + `SFTL_R0_SPAN + 1, 5);
        chk1("window high", 1'b1, fault[5]);
        xfer(1'b1, 8'h84, 32'h0000_0001);
        repeat (5) @(posedge sys_clk);
        chk1("seq no sync", 1'b0, seq_en);
        sync_in <= 1'b1;
        repeat (5) @(posedge sys_clk);
        chk1("seq sync", 1'b1, seq_en);
        xfer(1'b0, 8'h80, 32'h0000_0000);
        chk1("status seq", 1'b1, rd[17]);
        complete_run();
    end
endmodule
